// File: core/aadc_dcmp.sv
// Digital threshold comparators two to four with register port and interrupt.
//
// Function
// R1: Bits 15:13 pick one of eight measured sources for the compare.
// R2: Polarity bit 12 clear: interrupt when source is below threshold.
// R3: Polarity bit 12 set: interrupt when source is above threshold.
// R4: Bits 11:0 hold a 12-bit unsigned threshold.
// R5: The power state machine reset clears every source selector.
// R6: Configuration registers reset to selector 000, polarity 0, threshold 0.
// R7: A comparator evaluates only while enabled; enables reset cleared.
// R8: Compared values are the converter's stored 12-bit channel results.
// R9: Evaluate on each new selected result; pulse an interrupt when true.
`timescale 1ns/1ps
`default_nettype none

module aadc_dcmp (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Power state machine reset, one-cycle pulse
	input wire logic smReset,
	// Register port
	input wire aadc_pkg::aadc_bus_req_t busReq,
	output var logic [aadc_pkg::DATA_W-1:0] rdata,
	// Converter results with per-channel new-result strobes
	input wire aadc_pkg::aadc_samples_t samples,
	// Interrupt outputs
	output var logic [aadc_pkg::NUM_CMP-1:0] cmpIrqPulse,
	output var logic irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [aadc_pkg::NUM_CMP-1:0][aadc_pkg::DATA_W-1:0] cfg;
		logic [aadc_pkg::NUM_CMP-1:0] ena;
		logic [aadc_pkg::NUM_CMP-1:0] status;
		logic [aadc_pkg::NUM_CMP-1:0] mask;
		logic [aadc_pkg::DATA_W-1:0] rdata;
		logic [aadc_pkg::NUM_CMP-1:0] pulse;
		logic irq;
	} aadc_state_t;

	localparam aadc_state_t STATE_RESET = '{
		cfg: {aadc_pkg::NUM_CMP{aadc_pkg::CFG_RESET}},
		ena: aadc_pkg::ENA_RESET,
		status: aadc_pkg::MASK_RESET,
		mask: aadc_pkg::MASK_RESET,
		rdata: aadc_pkg::RDATA_IDLE,
		pulse: aadc_pkg::MASK_RESET,
		irq: 1'b0
	};

	aadc_state_t s_r;
	aadc_state_t s_nxt;

	// ==========================================================
	// Field access
	// Every 3-bit code names a source, so this cast cannot go out of range.
	function automatic aadc_pkg::aadc_src_t srcOf(
		input logic [aadc_pkg::DATA_W-1:0] cfg
	);
		logic [2:0] code;
		code = cfg[aadc_pkg::SRC_MSB:aadc_pkg::SRC_LSB];
		srcOf = aadc_pkg::aadc_src_t'(code); // R1
	endfunction

	function automatic logic polOf(
		input logic [aadc_pkg::DATA_W-1:0] cfg
	);
		polOf = cfg[aadc_pkg::POL_BIT];
	endfunction

	function automatic logic [aadc_pkg::SAMPLE_W-1:0] thrOf(
		input logic [aadc_pkg::DATA_W-1:0] cfg
	);
		thrOf = cfg[aadc_pkg::THR_MSB:0]; // R4
	endfunction

	// Replaces the selector field and leaves polarity and threshold alone.
	function automatic logic [aadc_pkg::DATA_W-1:0] withSrc(
		input logic [aadc_pkg::DATA_W-1:0] cfg,
		input logic [2:0] code
	);
		withSrc = cfg;
		withSrc[aadc_pkg::SRC_MSB:aadc_pkg::SRC_LSB] = code;
	endfunction

	// Bit 0 of the enable word is reserved and always reads zero.
	function automatic logic [aadc_pkg::NUM_CMP-1:0] enaField(
		input logic [aadc_pkg::DATA_W-1:0] word
	);
		enaField = word[aadc_pkg::ENA_MSB:aadc_pkg::ENA_LSB];
	endfunction

	function automatic logic [aadc_pkg::DATA_W-1:0] enaWord(
		input logic [aadc_pkg::NUM_CMP-1:0] ena
	);
		enaWord = aadc_pkg::RDATA_IDLE;
		enaWord[aadc_pkg::ENA_MSB:aadc_pkg::ENA_LSB] = ena;
	endfunction

	// Status and mask share one layout: a bit per comparator from bit 0.
	function automatic logic [aadc_pkg::NUM_CMP-1:0] cmpField(
		input logic [aadc_pkg::DATA_W-1:0] word
	);
		cmpField = word[aadc_pkg::NUM_CMP-1:0];
	endfunction

	function automatic logic [aadc_pkg::DATA_W-1:0] cmpWord(
		input logic [aadc_pkg::NUM_CMP-1:0] bits
	);
		cmpWord = aadc_pkg::RDATA_IDLE;
		cmpWord[aadc_pkg::NUM_CMP-1:0] = bits;
	endfunction

	// ==========================================================
	// Source routing
	// The slot order of the result bundle matches the selector codes.
	function automatic logic [aadc_pkg::SAMPLE_W-1:0] srcValue(
		input aadc_pkg::aadc_src_t src,
		input aadc_pkg::aadc_samples_t smp
	);
		srcValue = smp.data[src]; // R8
	endfunction

	function automatic logic srcFresh(
		input aadc_pkg::aadc_src_t src,
		input aadc_pkg::aadc_samples_t smp
	);
		srcFresh = smp.fresh[src]; // R9
	endfunction

	// ==========================================================
	// Compare
	// True when a fresh result of the selected source meets the condition.
	// Equality never fires: both directions compare strictly.
	function automatic logic cmpHit(
		input logic [aadc_pkg::DATA_W-1:0] cfg,
		input aadc_pkg::aadc_samples_t smp
	);
		aadc_pkg::aadc_src_t src;
		logic [aadc_pkg::SAMPLE_W-1:0] val;
		logic [aadc_pkg::SAMPLE_W-1:0] thr;
		src = srcOf(cfg);
		val = srcValue(src, smp);
		thr = thrOf(cfg);
		if (!srcFresh(src, smp)) begin // R9
			cmpHit = 1'b0;
		end else if (polOf(cfg)) begin
			cmpHit = val > thr; // R3
		end else begin
			cmpHit = val < thr; // R2
		end
	endfunction

	// ==========================================================
	// Address decode
	// Index of a configuration register, or NUM_CMP when not one.
	function automatic int cfgIndex(input logic [aadc_pkg::ADDR_W-1:0] a);
		unique case (a)
			aadc_pkg::ADDR_CMP2_CFG: cfgIndex = 0;
			aadc_pkg::ADDR_CMP3_CFG: cfgIndex = 1;
			aadc_pkg::ADDR_CMP4_CFG: cfgIndex = 2;
			default: cfgIndex = aadc_pkg::NUM_CMP;
		endcase
	endfunction

	function automatic logic isCfg(input logic [aadc_pkg::ADDR_W-1:0] a);
		isCfg = cfgIndex(a) < aadc_pkg::NUM_CMP;
	endfunction

	// ==========================================================
	// Events
	// Uses the configuration as it stood before any write in this cycle.
	function automatic logic [aadc_pkg::NUM_CMP-1:0] hitsOf(
		input aadc_state_t st,
		input aadc_pkg::aadc_samples_t smp
	);
		hitsOf = '0;
		for (int i = 0; i < aadc_pkg::NUM_CMP; i++) begin
			hitsOf[i] = st.ena[i] && cmpHit(st.cfg[i], smp); // R7
		end
	endfunction

	// A new event in the clearing cycle keeps its status bit set.
	function automatic logic [aadc_pkg::NUM_CMP-1:0] statusAfter(
		input logic [aadc_pkg::NUM_CMP-1:0] status,
		input logic [aadc_pkg::NUM_CMP-1:0] clr,
		input logic [aadc_pkg::NUM_CMP-1:0] hit
	);
		statusAfter = (status & ~clr) | hit;
	endfunction

	// ==========================================================
	// Register writes
	// Status bits that a write of ones asks to clear.
	function automatic logic [aadc_pkg::NUM_CMP-1:0] clearOf(
		input aadc_pkg::aadc_bus_req_t req
	);
		clearOf = '0;
		if (req.wr && req.addr == aadc_pkg::ADDR_INT_STATUS) begin
			clearOf = cmpField(req.wdata);
		end
	endfunction

	// Writes to unmapped addresses and to the status word change nothing here.
	function automatic aadc_state_t applyWrite(
		input aadc_state_t st,
		input aadc_pkg::aadc_bus_req_t req
	);
		int idx;
		idx = cfgIndex(req.addr);
		applyWrite = st;
		if (req.wr) begin
			if (isCfg(req.addr)) begin
				applyWrite.cfg[idx] = req.wdata;
			end
			unique case (req.addr)
				aadc_pkg::ADDR_ENABLE: begin
					applyWrite.ena = enaField(req.wdata);
				end
				aadc_pkg::ADDR_INT_MASK: begin
					applyWrite.mask = cmpField(req.wdata);
				end
				default: begin
				end
			endcase
		end
	endfunction

	// ==========================================================
	// Power state machine reset
	// Only selectors and enables return to default; polarity, threshold,
	// status and mask keep their values across a power sequence.
	function automatic aadc_state_t applySmReset(input aadc_state_t st);
		applySmReset = st;
		for (int i = 0; i < aadc_pkg::NUM_CMP; i++) begin
			applySmReset.cfg[i] =
				withSrc(st.cfg[i], aadc_pkg::SRC_RESET); // R5
		end
		applySmReset.ena = aadc_pkg::ENA_RESET; // R7
	endfunction

	// ==========================================================
	// Register reads
	// Reserved and unmapped bits read as zero.
	function automatic logic [aadc_pkg::DATA_W-1:0] readWord(
		input aadc_state_t st,
		input logic [aadc_pkg::ADDR_W-1:0] a
	);
		int idx;
		idx = cfgIndex(a);
		readWord = aadc_pkg::RDATA_IDLE;
		if (isCfg(a)) begin
			readWord = st.cfg[idx];
		end else begin
			unique case (a)
				aadc_pkg::ADDR_ENABLE: begin
					readWord = enaWord(st.ena);
				end
				aadc_pkg::ADDR_INT_STATUS: begin
					readWord = cmpWord(st.status);
				end
				aadc_pkg::ADDR_INT_MASK: begin
					readWord = cmpWord(st.mask);
				end
				default: begin
				end
			endcase
		end
	endfunction

	function automatic logic irqLevel(input aadc_state_t st);
		irqLevel = |(st.status & st.mask);
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic [aadc_pkg::NUM_CMP-1:0] hit;
		hit = hitsOf(s_r, samples);
		s_nxt = applyWrite(s_r, busReq);
		s_nxt.pulse = hit; // R9
		s_nxt.status = statusAfter(s_r.status, clearOf(busReq), hit);

		// The state machine reset overrides a software write in the same cycle.
		if (smReset) begin
			s_nxt = applySmReset(s_nxt);
		end

		// Registered so that the interrupt output comes from a flip-flop.
		s_nxt.irq = irqLevel(s_nxt);

		s_nxt.rdata = aadc_pkg::RDATA_IDLE;
		if (busReq.rd) begin
			s_nxt.rdata = readWord(s_r, busReq.addr);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= STATE_RESET; // R6
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign cmpIrqPulse = s_r.pulse;
	assign irq = s_r.irq;

endmodule

`default_nettype wire

// File: core/aadc_pkg.sv
// Shared constants and types for the auxiliary converter digital comparators.
package aadc_pkg;

	// ==========================================================
	// Register bus and map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_ENABLE = 8'ha3;
	localparam logic [7:0] ADDR_CMP2_CFG = 8'ha5;
	localparam logic [7:0] ADDR_CMP3_CFG = 8'ha6;
	localparam logic [7:0] ADDR_CMP4_CFG = 8'ha7;
	localparam logic [7:0] ADDR_INT_STATUS = 8'hb0;
	localparam logic [7:0] ADDR_INT_MASK = 8'hb1;

	// ==========================================================
	// Field layout
	localparam int NUM_CMP = 3;
	localparam int NUM_SRC = 8;
	localparam int SAMPLE_W = 12;
	localparam int SRC_MSB = 15;
	localparam int SRC_LSB = 13;
	localparam int POL_BIT = 12;
	localparam int THR_MSB = 11;
	localparam int ENA_LSB = 1;
	localparam int ENA_MSB = 3;

	// ==========================================================
	// Reset values
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [2:0] ENA_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [15:0] RDATA_IDLE = 16'h0000;

	// ==========================================================
	// Source codes for the selector field
	typedef enum logic [2:0] {
		AADC_SRC_AUX_INPUT_ONE,
		AADC_SRC_AUX_INPUT_TWO,
		AADC_SRC_AUX_INPUT_THREE,
		AADC_SRC_AUX_INPUT_FOUR,
		AADC_SRC_USB_VOLTAGE,
		AADC_SRC_LINE_VOLTAGE,
		AADC_SRC_BATTERY_VOLTAGE_SAMPLE,
		AADC_SRC_CHIP_TEMPERATURE
	} aadc_src_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [NUM_SRC-1:0] fresh;
		logic [NUM_SRC-1:0][SAMPLE_W-1:0] data;
	} aadc_samples_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} aadc_bus_req_t;

endpackage

// File: tb/aadc_dcmp_assertions.sv
// Port checker for the threshold comparator block.
`timescale 1ns/1ps
`default_nettype none
module aadc_dcmp_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Inputs
	input wire logic smReset,
	input wire aadc_pkg::aadc_bus_req_t busReq,
	input wire aadc_pkg::aadc_samples_t samples,
	// Outputs
	input wire logic [15:0] rdata,
	input wire logic [2:0] cmpIrqPulse,
	input wire logic irq
);
	// ==========================================================
	// Properties
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_rdata_idle: assert property (
		!$past(busReq.rd) |-> rdata == 16'h0) else $error("rdata not idle");
	a_cfg_readback: assert property (
		busReq.rd && $past(busReq.wr, 2) && !$past(busReq.wr) &&
		busReq.addr == $past(busReq.addr, 2) &&
		busReq.addr inside {8'ha5, 8'ha6, 8'ha7}
		|=> rdata[12:0] == $past(busReq.wdata[12:0], 3))
		else $error("cfg readback");
	a_no_fresh_quiet: assert property (
		samples.fresh == 8'h0 |=> cmpIrqPulse == 3'h0)
		else $error("pulse without result");
	a_sm_disables: assert property (
		smReset |-> ##2 cmpIrqPulse == 3'h0) else $error("pulse after sm");
	a_sm_clears_sel: assert property (
		smReset ##1 busReq.rd && busReq.addr == 8'ha5
		|=> rdata[15:13] == 3'h0) else $error("selector kept");
	a_rst_quiet: assert property (
		$rose(rstn) |-> !irq && rdata == 16'h0 && cmpIrqPulse == 3'h0)
		else $error("outputs after reset");
	a_irq_rise: assert property (
		$rose(irq) |-> $past(busReq.wr) || cmpIrqPulse != 3'h0)
		else $error("irq rise");
	a_irq_fall: assert property (
		$fell(irq) |-> $past(busReq.wr)) else $error("irq fall");
	cover property (cmpIrqPulse[2]);
	cover property ($fell(irq));
	cover property (smReset ##1 busReq.rd);
endmodule
bind aadc_dcmp aadc_dcmp_assertions chk_u (
	.clk(clk),
	.rstn(rstn),
	.smReset(smReset),
	.busReq(busReq),
	.samples(samples),
	.rdata(rdata),
	.cmpIrqPulse(cmpIrqPulse),
	.irq(irq)
);
`default_nettype wire

// File: tb/aadc_dcmp_tb_top.sv
// Self-checking bench for the threshold comparator block.
`timescale 1ns/1ps
`default_nettype none
module aadc_dcmp_tb_top;
	logic clk, rstn, smReset, irq;
	logic [15:0] rdata;
	logic [2:0] cmpIrqPulse;
	aadc_pkg::aadc_bus_req_t busReq;
	aadc_pkg::aadc_samples_t samples;
	int err_total, n_compared;
	logic [7:0] regs [7] = '{8'ha3, 8'ha5, 8'ha6, 8'ha7, 8'hb0, 8'hb1, 8'h0};
	aadc_dcmp dut_u (
		.clk(clk),
		.rstn(rstn),
		.smReset(smReset),
		.busReq(busReq),
		.rdata(rdata),
		.samples(samples),
		.cmpIrqPulse(cmpIrqPulse),
		.irq(irq)
	);
	// ==========================================================
	// Tasks
	task automatic close_out;
		$display("mismatches %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Writes leave an idle cycle so the strobe is never driven twice at once.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		busReq.addr <= a;
		busReq.wdata <= d;
		busReq.wr <= 1'b1;
		@(posedge clk);
		busReq.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		busReq.addr <= a;
		busReq.rd <= 1'b1;
		@(posedge clk);
		busReq.rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
		@(posedge clk);
	endtask
	task automatic ev(input int s, input logic [11:0] v, input logic [2:0] e);
		samples.data[s] <= v;
		samples.fresh <= 8'h01 << s;
		@(posedge clk);
		samples.fresh <= 8'h0;
		#1 cmp("pulse", {13'h0, e}, {13'h0, cmpIrqPulse});
		@(posedge clk);
	endtask
	task automatic chkIrq(input logic e);
		#1 cmp("irq", {15'h0, e}, {15'h0, irq});
	endtask
	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		err_total++;
		close_out();
	end
	initial begin
		rstn = 1'b0;
		smReset = 1'b0;
		busReq = '0;
		samples = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (regs[i])
			rd(regs[i], 16'h0);
		wr(8'ha3, 16'hffff);
		rd(8'ha3, 16'h000e);
		wr(8'hb1, 16'h0007);
		for (int s = 0; s < 8; s++) begin
			wr(8'ha5, {s[2:0], 1'b1, 12'h100});
			ev(s, 12'h101, 3'b001);
		end
		chkIrq(1'b1);
		rd(8'hb0, 16'h0001);
		wr(8'hb0, 16'h0001);
		chkIrq(1'b0);
		wr(8'ha6, 16'h2800);
		rd(8'ha6, 16'h2800);
		ev(1, 12'h7ff, 3'b010);
		ev(1, 12'h800, 3'b000);
		wr(8'ha7, 16'h5ffe);
		ev(2, 12'hfff, 3'b100);
		ev(2, 12'hffe, 3'b000);
		wr(8'hb1, 16'h0);
		chkIrq(1'b0);
		wr(8'hb1, 16'h0004);
		chkIrq(1'b1);
		rd(8'hb0, 16'h0006);
		wr(8'hb0, 16'h0007);
		ev(1, 12'h0, 3'b010);
		chkIrq(1'b0);
		// An event in the cycle that clears its status bit must keep it set.
		busReq.addr <= 8'hb0;
		busReq.wdata <= 16'h0002;
		busReq.wr <= 1'b1;
		samples.fresh <= 8'h02;
		@(posedge clk);
		busReq.wr <= 1'b0;
		samples.fresh <= 8'h00;
		@(posedge clk);
		rd(8'hb0, 16'h0002);
		wr(8'ha5, 16'hf123);
		smReset <= 1'b1;
		@(posedge clk);
		smReset <= 1'b0;
		rd(8'ha5, 16'h1123);
		rd(8'ha3, 16'h0);
		ev(0, 12'hfff, 3'b000);
		// A second reset in mid-run must bring the CMP3 configuration, status and mask registers back to default.
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(8'ha6, 16'h0);
		rd(8'hb0, 16'h0);
		rd(8'hb1, 16'h0);
		close_out();
	end
endmodule
`default_nettype wire
